// File: rtl/dsl_load_port.sv
// Serial load port that drives two DAC codes
`timescale 1ns/1ps
module dsl_load_port (
	input  wire logic        core_clk,             // Core clock, 250 MHz
	input  wire logic        arst_n,               // Register reset, low active
	input  wire logic        serialClk,            // Serial shift clock pin
	input  wire logic        serialDataIn,         // Serial data pin
	input  wire logic        writeLatchStrobe,     // Write latch strobe pin
	output logic      [9:0]  gainControlDacCode,   // Code for the log attenuator
	output logic      [9:0]  auxiliaryDacCode,     // Spare code, e.g. iris
	output logic      [11:0] gainDacMv,            // Gain DAC level, mV
	output logic      [11:0] auxDacMv,             // Auxiliary DAC level, mV
	output logic             maxGain,              // Gain code selects max gain
	output logic      [11:0] parallelWord,         // Last latched word
	output logic             wordComplete          // Twelve or more bits held
);

	// Pin synchronisers, first stage read only by second
	logic [2:0] sclkSync_q;
	logic [1:0] dataSync_q;
	logic [2:0] wrtSync_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclkSync_q <= 3'h0;
			dataSync_q <= 2'h0;
			wrtSync_q  <= 3'h0;
		end else begin
			sclkSync_q <= {sclkSync_q[1:0], serialClk};
			dataSync_q <= {dataSync_q[0], serialDataIn};
			wrtSync_q  <= {wrtSync_q[1:0], writeLatchStrobe};
		end
	end

	// Edge detection on the synchronised copies only
	logic sclkRise;
	logic sclkFall;
	logic wrtRise;
	logic dataBit;

	assign sclkRise = sclkSync_q[1] & ~sclkSync_q[2];
	assign sclkFall = ~sclkSync_q[1] & sclkSync_q[2];
	assign wrtRise  = wrtSync_q[1] & ~wrtSync_q[2];
	assign dataBit  = dataSync_q[1];

	// Master and slave stages of the serial register
	logic [11:0] master_q;
	logic [11:0] slave_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			master_q <= dsl_pkg::SHIFT_RESET;
		end else if (sclkRise) begin
			master_q <= {slave_q[10:0], dataBit};
		end
	end

	// twelve-bit shift register
	// Slave moves only on the fall, so a clock parked high holds the word
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			slave_q <= dsl_pkg::SHIFT_RESET;
		end else if (sclkFall) begin
			slave_q <= master_q;
		end
	end

	// Bit counter saturates once a full word is held
	logic [3:0] bitCount_q;
	logic [3:0] bitCount_d;

	always_comb begin
		bitCount_d = bitCount_q;
		if (wrtRise) begin
			bitCount_d = dsl_pkg::COUNT_RESET;
		end else if (sclkFall && bitCount_q != dsl_pkg::WORD_BITS) begin
			bitCount_d = bitCount_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bitCount_q <= dsl_pkg::COUNT_RESET;
		end else begin
			bitCount_q <= bitCount_d;
		end
	end

	// Word tracking state
	dsl_pkg::dsl_state_type state_q;
	dsl_pkg::dsl_state_type state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			dsl_pkg::DSL_IDLE: begin
				if (sclkFall) begin
					state_d = dsl_pkg::DSL_SHIFT;
				end
			end
			dsl_pkg::DSL_SHIFT: begin
				if (wrtRise) begin
					state_d = dsl_pkg::DSL_IDLE;
				end else if (bitCount_d == dsl_pkg::WORD_BITS) begin
					state_d = dsl_pkg::DSL_FULL;
				end
			end
			dsl_pkg::DSL_FULL: begin
				if (wrtRise) begin
					state_d = dsl_pkg::DSL_IDLE;
				end
			end
			default: begin
				state_d = dsl_pkg::DSL_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= dsl_pkg::DSL_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign wordComplete = (state_q == dsl_pkg::DSL_FULL);

	// copy on strobe
	// The write to a code register trails the copy by one cycle, the strobe by two
	logic writeGo_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			parallelWord <= dsl_pkg::SHIFT_RESET;
			writeGo_q    <= 1'b0;
		end else begin
			writeGo_q <= wrtRise;
			if (wrtRise) begin
				parallelWord <= slave_q;
			end
		end
	end

	function automatic logic selValid(input logic [1:0] sel);
		selValid = (sel == dsl_pkg::SEL_GAIN) || (sel == dsl_pkg::SEL_AUX);
	endfunction

	logic [1:0] wordSel;
	logic       codeWrEn;

	assign wordSel  = parallelWord[dsl_pkg::SEL_MSB:dsl_pkg::SEL_LSB];
	assign codeWrEn = writeGo_q & selValid(wordSel);

	// all code registers cleared by arst_n
	dsl_code_regs #(
		.WIDTH(dsl_pkg::CODE_WIDTH)
	) u_codes (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.wrEn     (codeWrEn),
		.wrIndex  (wordSel == dsl_pkg::SEL_AUX),
		.wrData   (parallelWord[dsl_pkg::CODE_MSB:0]),
		.gainCode (gainControlDacCode),
		.auxCode  (auxiliaryDacCode)
	);

	function automatic logic [11:0] codeToMv(input logic [9:0] code);
		int prod;
		prod = int'(code) * (dsl_pkg::MV_AT_ZERO - dsl_pkg::MV_AT_ONES);
		codeToMv = 12'(dsl_pkg::MV_AT_ZERO - prod / dsl_pkg::CODE_FULL);
	endfunction

	// Levels lag the codes by one cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gainDacMv <= 12'(dsl_pkg::MV_AT_ZERO);
			auxDacMv  <= 12'(dsl_pkg::MV_AT_ZERO);
			maxGain   <= 1'b1;
		end else begin
			gainDacMv <= codeToMv(gainControlDacCode);
			auxDacMv  <= codeToMv(auxiliaryDacCode);
			maxGain   <= (gainControlDacCode == dsl_pkg::CODE_RESET);
		end
	end

	// Checks
	chk_master_capture: assert property (@(posedge core_clk) disable iff (!arst_n)
		sclkRise |=> master_q == {$past(slave_q[10:0]), $past(dataBit)})
		else $error("master did not capture on serial clock rise");

	chk_slave_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		!sclkFall |=> $stable(slave_q))
		else $error("slave moved without a serial clock fall");

	chk_slave_take: assert property (@(posedge core_clk) disable iff (!arst_n)
		sclkFall |=> slave_q == $past(master_q))
		else $error("slave did not take master on fall");

	chk_strobe_copy: assert property (@(posedge core_clk) disable iff (!arst_n)
		wrtRise |=> parallelWord == $past(slave_q))
		else $error("parallel word not copied on strobe");

	chk_gain_write: assert property (@(posedge core_clk) disable iff (!arst_n)
		wrtRise && slave_q[11:10] == dsl_pkg::SEL_GAIN
		|=> ##1 gainControlDacCode == $past(slave_q[9:0], 2))
		else $error("gain code not written two cycles after strobe");

	chk_aux_write: assert property (@(posedge core_clk) disable iff (!arst_n)
		wrtRise && slave_q[11:10] == dsl_pkg::SEL_AUX
		|=> ##1 auxiliaryDacCode == $past(slave_q[9:0], 2) && $stable(gainControlDacCode))
		else $error("aux code write wrong or disturbed gain");

	chk_inverse_ends: assert property (@(posedge core_clk) disable iff (!arst_n)
		auxiliaryDacCode == 10'h3ff |=> auxDacMv == 12'h12c)
		else $error("all-ones code does not give lowest level");

	chk_max_gain: assert property (@(posedge core_clk) disable iff (!arst_n)
		gainControlDacCode == 10'h000 |=> maxGain && gainDacMv == 12'h960)
		else $error("zero gain code does not give max gain");

	chk_word_full: assert property (@(posedge core_clk) disable iff (!arst_n)
		wordComplete |-> bitCount_q == dsl_pkg::WORD_BITS)
		else $error("word flagged complete before twelve bits");

endmodule

// File: rtl/dsl_pkg.sv
// Constants and types for the serial DAC load port
package dsl_pkg;

	localparam int SHIFT_WIDTH = 12;
	localparam int CODE_WIDTH  = 10;
	localparam int SEL_WIDTH   = 2;
	localparam int MV_WIDTH    = 12;

	// Field positions inside the twelve-bit word
	localparam int SEL_MSB  = 11;
	localparam int SEL_LSB  = 10;
	localparam int CODE_MSB = 9;

	// Select codes; the remaining two values are ignored
	localparam logic [1:0] SEL_GAIN = 2'h0;
	localparam logic [1:0] SEL_AUX  = 2'h1;

	// Values after reset
	localparam logic [11:0] SHIFT_RESET = 12'h000;
	localparam logic [9:0]  CODE_RESET  = 10'h000;
	localparam logic [3:0]  COUNT_RESET = 4'h0;

	// Output voltage ends of the inverse code, in millivolts
	localparam int MV_AT_ZERO = 2400;
	localparam int MV_AT_ONES = 300;
	localparam int CODE_FULL  = 1023;

	// Bits counted before a word is complete
	localparam logic [3:0] WORD_BITS = 4'hc;

	// Word tracking states
	typedef enum logic [2:0] {
		DSL_IDLE  = 3'b001,
		DSL_SHIFT = 3'b010,
		DSL_FULL  = 3'b100
	} dsl_state_type;

endpackage

// File: rtl/dsl_code_regs.sv
// Holds the two DAC code registers
`timescale 1ns/1ps
module dsl_code_regs #(
	parameter int WIDTH = 10
) (
	input  wire logic             core_clk,  // Core clock
	input  wire logic             arst_n,    // Async reset, low active
	input  wire logic             wrEn,      // Write pulse
	input  wire logic             wrIndex,   // 0 gain, 1 auxiliary
	input  wire logic [WIDTH-1:0] wrData,    // Code to store
	output logic      [WIDTH-1:0] gainCode,  // Gain code register
	output logic      [WIDTH-1:0] auxCode    // Auxiliary code register
);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gainCode <= dsl_pkg::CODE_RESET;
			auxCode  <= dsl_pkg::CODE_RESET;
		end else if (wrEn) begin
			if (wrIndex) begin
				auxCode <= wrData;
			end else begin
				gainCode <= wrData;
			end
		end
	end

endmodule

// File: testbench/dsl_ctrl_model.sv
// Controller model that writes words over the serial load port
`timescale 1ns/1ps
module dsl_ctrl_model (
	input  wire logic core_clk,         // Core clock, paces the link
	output logic      serialClk,        // Serial shift clock
	output logic      serialDataIn,     // Serial data
	output logic      writeLatchStrobe  // Write latch strobe
);
	localparam int HALF = 20; // 80 ns half period of the link clock

	initial begin
		serialClk = 1'b0;
		serialDataIn = 1'b0;
		writeLatchStrobe = 1'b0;
	end

	// Wait n core cycles, landing on a falling edge
	task automatic pause(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic send(input logic [15:0] word, input int nbits);
		for (int i = nbits - 1; i >= 0; i--) begin
			serialDataIn = word[i];
			pause(HALF / 2);
			serialClk = 1'b1;
			pause(HALF);
			serialClk = 1'b0;
			pause(HALF / 2);
		end
		// Released line shows the inverse, not a stale bit
		serialDataIn = ~serialDataIn;
	endtask

	task automatic strobe();
		pause(HALF);
		writeLatchStrobe = 1'b1;
		pause(HALF);
		writeLatchStrobe = 1'b0;
		pause(HALF);
	endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the serial DAC load port
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin badCount++; \
	$display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb;
	logic        core_clk;
	logic        arst_n;
	logic        serialClk;
	logic        serialDataIn;
	logic        writeLatchStrobe;
	logic [9:0]  gainCode;
	logic [9:0]  auxCode;
	logic [11:0] gainMv;
	logic [11:0] auxMv;
	logic        maxGain;
	logic [11:0] word;
	logic        full;
	int          badCount;
	int          checks;

	// Core clock, 4 ns period
	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	dsl_load_port u_dsl_load_port (
		.core_clk           (core_clk),
		.arst_n             (arst_n),
		.serialClk          (serialClk),
		.serialDataIn       (serialDataIn),
		.writeLatchStrobe   (writeLatchStrobe),
		.gainControlDacCode (gainCode),
		.auxiliaryDacCode   (auxCode),
		.gainDacMv          (gainMv),
		.auxDacMv           (auxMv),
		.maxGain            (maxGain),
		.parallelWord       (word),
		.wordComplete       (full)
	);

	dsl_ctrl_model u_dsl_ctrl_model (
		.core_clk         (core_clk),
		.serialClk        (serialClk),
		.serialDataIn     (serialDataIn),
		.writeLatchStrobe (writeLatchStrobe)
	);

	// Inverse code level, truncated like the design's model
	function automatic logic [11:0] mvOf(input logic [9:0] code);
		return 12'(2400 - (int'(code) * 2100) / 1023);
	endfunction

	// Compare every held output except the full flag in one go
	task automatic expectAll(input logic [9:0] g, input logic [9:0] a, input logic [11:0] w);
		`CHK("gainCode", g, gainCode)
		`CHK("auxCode", a, auxCode)
		`CHK("parallelWord", w, word)
		`CHK("gainMv", mvOf(g), gainMv)
		`CHK("auxMv", mvOf(a), auxMv)
		`CHK("maxGain", (g == 10'h000), maxGain)
	endtask

	// Shift a word, then latch it; full flag must rise and drop
	task automatic load(input logic [15:0] w, input int n);
		u_dsl_ctrl_model.send(w, n);
		`CHK("fullBefore", 1'b1, full)
		u_dsl_ctrl_model.strobe();
		`CHK("fullAfter", 1'b0, full)
	endtask

	task automatic checkReset();
		expectAll(10'h000, 10'h000, 12'h000);
		`CHK("fullReset", 1'b0, full)
	endtask

	task automatic writeGain();
		load(16'h03ff, 12);
		expectAll(10'h3ff, 10'h000, 12'h3ff);
	endtask

	task automatic overflowAux();
		load(16'h3555, 14);
		expectAll(10'h3ff, 10'h155, 12'h555);
	endtask

	// all-ones auxiliary code gives lowest level
	task automatic auxOnes();
		load(16'h07ff, 12);
		expectAll(10'h3ff, 10'h3ff, 12'h7ff);
	endtask

	// selects two and three change no code
	// Codes differ from both held values, so a stray write shows
	task automatic ignoredSelect();
		load(16'h0a5a, 12);
		expectAll(10'h3ff, 10'h3ff, 12'ha5a);
		load(16'h0f0f, 12);
		expectAll(10'h3ff, 10'h3ff, 12'hf0f);
	endtask

	// reset mid-word clears everything at once
	task automatic midReset();
		u_dsl_ctrl_model.send(16'h003f, 6);
		arst_n = 1'b0;
		#1;
		expectAll(10'h000, 10'h000, 12'h000);
		repeat (3) @(negedge core_clk);
		arst_n = 1'b1;
		// Stale ones in the shift register would show here
		u_dsl_ctrl_model.send(16'h0015, 6);
		u_dsl_ctrl_model.strobe();
		expectAll(10'h015, 10'h000, 12'h015);
	endtask

	// zero gain code restores max gain
	task automatic gainZero();
		load(16'h0000, 12);
		expectAll(10'h000, 10'h000, 12'h000);
	endtask

	task automatic close_out();
		if (badCount == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		badCount = 0;
		checks = 0;
		arst_n = 1'b0;
		repeat (6) @(negedge core_clk);
		checkReset();
		arst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		checkReset();
		writeGain();
		overflowAux();
		auxOnes();
		ignoredSelect();
		midReset();
		gainZero();
		close_out();
	end
endmodule
